// file: pkg/tmr2_map.vh
// Register offsets, field positions and reset values of the capture/reload timer
`ifndef TMR2_MAP_VH
`define TMR2_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define TMR2_ADDR_CONTROL  8'hc8
`define TMR2_ADDR_MODE     8'hc9
`define TMR2_ADDR_CAP_LOW  8'hca
`define TMR2_ADDR_CAP_HIGH 8'hcb
`define TMR2_ADDR_CNT_LOW  8'hcc
`define TMR2_ADDR_CNT_HIGH 8'hcd
`define TMR2_ADDR_IRQ_STAT 8'hce
`define TMR2_ADDR_IRQ_MASK 8'hcf
// ****************************************
// Control register fields
// ****************************************
`define TMR2_CTL_OVF      7
`define TMR2_CTL_EXT      6
`define TMR2_CTL_RX_BAUD  5
`define TMR2_CTL_TX_BAUD  4
`define TMR2_CTL_TRIG_EN  3
`define TMR2_CTL_RUN      2
`define TMR2_CTL_CNT_SRC  1
`define TMR2_CTL_CAP_SEL  0
// ****************************************
// Mode register fields
// ****************************************
`define TMR2_MOD_CAP_CLR  3
`define TMR2_MOD_CLK_OUT  1
`define TMR2_MOD_DOWN_EN  0
`define TMR2_MOD_MASK     8'h0b
// ****************************************
// Interrupt status fields and reset values
// ****************************************
`define TMR2_IRQ_OVF      0
`define TMR2_IRQ_EXT      1
`define TMR2_IRQ_MASK_ALL 8'h03
`define TMR2_RST_BYTE     8'h00
`define TMR2_RST_WORD     16'h0000
// ****************************************
// Timing
// ****************************************
`define TMR2_BAUD_DIV     2
`define TMR2_SLOW_DIV     12
`endif

// file: verilog/tmr2_timer.v
// Sixteen-bit capture / auto-reload timer with baud time-base and clock-out
// What this block does
// - Overflow flag on wrap or down-count match
// - Hardware sets overflow only without baud selects
// - External flag from trigger edge or down-count overflow
// - External flag raises timer interrupt when enabled
// - Receive baud select picks serial receive time-base
// - Transmit baud select picks serial transmit time-base
// - Baud mode forces auto-reload on every overflow
// - Trigger enable gates trigger pin falling edges
// - Run control stops counting; trigger edges can still reload or auto-clear the count
// - Count source: internal tick or pin edges
// - Baud mode advances every two device clocks
// - Reload mode reloads on up-count overflow or trigger
// - Capture mode copies count on trigger edge
// - Capture auto-clear zeroes count on capture
// - Clock-out active only while enabled
// - Down-count enable and trigger set direction
// - Capture registers hold capture or reload value
`timescale 1ns/1ps
`include "tmr2_map.vh"

module tmr2_timer #(
  parameter SLOW_DIV = `TMR2_SLOW_DIV
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Pins
  input  wire       count_input_pin,
  input  wire       trigger_pin,
  output reg        clock_out,
  output wire       clock_out_oe,
  // Serial port 0 time-base
  input  wire       timer1_overflow,
  input  wire [1:0] serial_mode,
  output wire       rx_baud_tick,
  output wire       tx_baud_tick,
  // Interrupts
  output wire       timer_irq_req,
  output wire       irq
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  control;
  reg  [3:0]  mode_bits;
  reg  [15:0] count;
  reg  [15:0] capture;
  reg  [1:0]  irq_stat;
  reg  [1:0]  irq_mask;
  reg  [1:0]  cin_sync;
  reg  [1:0]  trg_sync;
  reg         cin_last;
  reg         trg_last;
  reg         baud_phase;
  reg  [7:0]  slow_cnt;

  wire overflow_flag         = control[`TMR2_CTL_OVF];
  wire external_edge_flag    = control[`TMR2_CTL_EXT];
  wire rx_baud_sel           = control[`TMR2_CTL_RX_BAUD];
  wire tx_baud_sel           = control[`TMR2_CTL_TX_BAUD];
  wire trigger_enable        = control[`TMR2_CTL_TRIG_EN];
  wire run_control           = control[`TMR2_CTL_RUN];
  wire count_source_select   = control[`TMR2_CTL_CNT_SRC];
  wire capture_reload_select = control[`TMR2_CTL_CAP_SEL];
  wire capture_auto_clear    = mode_bits[3];
  wire clock_out_enable      = mode_bits[1];
  wire down_count_enable     = mode_bits[0];
  wire baud_mode             = rx_baud_sel | tx_baud_sel;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  // Count pin: two stages, then one more for the edge; reset to the idle high level
  // so that no false falling edge follows reset
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cin_sync <= 2'h3;
      cin_last <= 1'b1;
    end else begin
      cin_sync <= {cin_sync[0], count_input_pin};
      cin_last <= cin_sync[1];
    end
  end

  // Trigger pin: same structure; its level also sets the count direction
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      trg_sync <= 2'h3;
      trg_last <= 1'b1;
    end else begin
      trg_sync <= {trg_sync[0], trigger_pin};
      trg_last <= trg_sync[1];
    end
  end

  wire cin_fall  = cin_last & ~cin_sync[1];
  wire trg_level = trg_sync[1];
  // Edges are ignored entirely while generating baud clocks
  wire trg_fall  = trg_last & ~trg_level & trigger_enable & ~baud_mode;

  // ****************************************
  // Tick generation
  // ****************************************
  // Internal tick uses a prescaler; tick rate select is outside this block, so the divider is a parameter
  wire slow_tick = (slow_cnt == SLOW_DIV[7:0] - 8'h01);
  always @(posedge clk_sys) begin
    if (sys_rst)
      slow_cnt <= 8'h00;
    else if (slow_tick)
      slow_cnt <= 8'h00;
    else
      slow_cnt <= slow_cnt + 8'h01;
  end

  // Free-running half-rate phase; baud ticks land on every second clock
  always @(posedge clk_sys) begin
    if (sys_rst)
      baud_phase <= 1'b0;
    else
      baud_phase <= ~baud_phase;
  end

  reg tick;
  always @* begin
    if (!run_control)
      tick = 1'b0;
    else if (baud_mode)
      tick = baud_phase;
    else if (count_source_select)
      tick = cin_fall;
    else
      tick = slow_tick;
  end

  // ****************************************
  // Counting direction and overflow
  // ****************************************
  wire reload_mode = baud_mode | ~capture_reload_select;
  wire count_down  = reload_mode & ~baud_mode & down_count_enable & ~trg_level;
  wire up_wrap     = tick & ~count_down & (count == 16'hffff);
  wire down_match  = tick & count_down & (count == capture);
  wire overflow    = up_wrap | down_match;

  // ****************************************
  // Register writes and count update
  // ****************************************
  // One strobe per register; nothing fires for an unmapped address
  reg wr_ctl;
  reg wr_mode;
  reg wr_capl;
  reg wr_caph;
  reg wr_cntl;
  reg wr_cnth;
  reg wr_stat;
  reg wr_mask;

  always @* begin
    wr_ctl  = 1'b0;
    wr_mode = 1'b0;
    wr_capl = 1'b0;
    wr_caph = 1'b0;
    wr_cntl = 1'b0;
    wr_cnth = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `TMR2_ADDR_CONTROL:  wr_ctl  = 1'b1;
        `TMR2_ADDR_MODE:     wr_mode = 1'b1;
        `TMR2_ADDR_CAP_LOW:  wr_capl = 1'b1;
        `TMR2_ADDR_CAP_HIGH: wr_caph = 1'b1;
        `TMR2_ADDR_CNT_LOW:  wr_cntl = 1'b1;
        `TMR2_ADDR_CNT_HIGH: wr_cnth = 1'b1;
        `TMR2_ADDR_IRQ_STAT: wr_stat = 1'b1;
        `TMR2_ADDR_IRQ_MASK: wr_mask = 1'b1;
        default:             wr_ctl  = 1'b0;
      endcase
    end
  end

  wire do_capture = trg_fall & capture_reload_select & ~baud_mode;
  wire do_reload  = (overflow & reload_mode & ~count_down)
                  | (trg_fall & reload_mode);
  wire hw_ovf_set = overflow & ~baud_mode;
  // Trigger edge sets the external flag; overflow sets it only in up/down mode
  wire hw_ext_set = trg_fall | (overflow & count_down & reload_mode);
  wire sw_ext_set = wr_ctl & reg_wdata[`TMR2_CTL_EXT] & ~external_edge_flag;

  reg [15:0] next_count;
  always @* begin
    next_count = count;
    if (tick)
      next_count = count_down ? count - 16'h0001 : count + 16'h0001;
    if (do_reload)
      next_count = count_down ? 16'hffff : capture;
    if (do_capture & capture_auto_clear)
      next_count = `TMR2_RST_WORD;
    if (wr_cntl)
      next_count = {next_count[15:8], reg_wdata};
    if (wr_cnth)
      next_count = {reg_wdata, next_count[7:0]};
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      count <= `TMR2_RST_WORD;
    else
      count <= next_count;
  end

  // ****************************************
  // Control register
  // ****************************************
  // Software write lands first; a hardware set in the same cycle wins over a clear
  reg [7:0] next_control;
  always @* begin
    next_control = control;
    if (wr_ctl)
      next_control = reg_wdata;
    if (hw_ovf_set)
      next_control[`TMR2_CTL_OVF] = 1'b1;
    if (hw_ext_set)
      next_control[`TMR2_CTL_EXT] = 1'b1;
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      control <= `TMR2_RST_BYTE;
    else
      control <= next_control;
  end

  // ****************************************
  // Mode register
  // ****************************************
  // Unused positions are stored as zero so reads stay clean
  always @(posedge clk_sys) begin
    if (sys_rst)
      mode_bits <= 4'h0;
    else if (wr_mode)
      mode_bits <= {reg_wdata[`TMR2_MOD_CAP_CLR], 1'b0, reg_wdata[`TMR2_MOD_CLK_OUT], reg_wdata[`TMR2_MOD_DOWN_EN]};
  end

  // ****************************************
  // Capture / reload register
  // ****************************************
  // A capture edge beats a software write in the same cycle
  reg [15:0] next_capture;
  always @* begin
    next_capture = capture;
    if (wr_capl)
      next_capture[7:0] = reg_wdata;
    if (wr_caph)
      next_capture[15:8] = reg_wdata;
    if (do_capture)
      next_capture = count;
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      capture <= `TMR2_RST_WORD;
    else
      capture <= next_capture;
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  wire ovf_clr = wr_stat & reg_wdata[`TMR2_IRQ_OVF];
  wire ext_clr = wr_stat & reg_wdata[`TMR2_IRQ_EXT];

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      // Set wins over a write-one-to-clear in the same cycle, so no event is lost
      irq_stat[`TMR2_IRQ_OVF] <= hw_ovf_set | (irq_stat[`TMR2_IRQ_OVF] & ~ovf_clr);
      irq_stat[`TMR2_IRQ_EXT] <= hw_ext_set | sw_ext_set | (irq_stat[`TMR2_IRQ_EXT] & ~ext_clr);
      if (wr_mask)
        irq_mask <= reg_wdata[1:0];
    end
  end

  // ****************************************
  // Clock-out
  // ****************************************
  // Square wave follows overflows, held low while disabled
  always @(posedge clk_sys) begin
    if (sys_rst)
      clock_out <= 1'b0;
    else if (!clock_out_enable)
      clock_out <= 1'b0;
    else if (overflow)
      clock_out <= ~clock_out;
  end

  assign clock_out_oe = clock_out_enable;

  // ****************************************
  // Serial time-base selection
  // ****************************************
  wire var_mode = serial_mode[0];  // Modes 1 and 3 use a variable rate
  assign rx_baud_tick = var_mode & (rx_baud_sel ? overflow : timer1_overflow);
  assign tx_baud_tick = var_mode & (tx_baud_sel ? overflow : timer1_overflow);

  // ****************************************
  // Interrupts
  // ****************************************
  // Processor-side request mirrors the two flags; enable is applied by the interrupt controller
  assign timer_irq_req = overflow_flag | external_edge_flag;
  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Read data
  // ****************************************
  // Idle cycles return zero so the port can be OR-ed onto a shared bus
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TMR2_ADDR_CONTROL:  next_rdata = control;
        `TMR2_ADDR_MODE:     next_rdata = {4'h0, mode_bits} & `TMR2_MOD_MASK;
        `TMR2_ADDR_CAP_LOW:  next_rdata = capture[7:0];
        `TMR2_ADDR_CAP_HIGH: next_rdata = capture[15:8];
        `TMR2_ADDR_CNT_LOW:  next_rdata = count[7:0];
        `TMR2_ADDR_CNT_HIGH: next_rdata = count[15:8];
        `TMR2_ADDR_IRQ_STAT: next_rdata = {6'h00, irq_stat};
        `TMR2_ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

endmodule // tmr2_timer

// file: bench/tmr2_sva.sv
// Port assertions for the capture/reload timer
`timescale 1ns/1ps
module tmr2_sva #(
  parameter SLOW_DIV = 12
) (
  // Clock and reset
  input wire       clk_sys,
  input wire       sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  // Outputs and serial time-base inputs
  input wire       clock_out,
  input wire       clock_out_oe,
  input wire       timer1_overflow,
  input wire [1:0] serial_mode,
  input wire       rx_baud_tick,
  input wire       tx_baud_tick,
  input wire       timer_irq_req,
  input wire       irq
);
  reg  rx_sel;
  reg  tx_sel;
  reg  quiet;
  wire ctl_wr = reg_wr && reg_addr == 8'hc8;
  // Baud selects change only by software, so a shadow is exact
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_sel <= 1'b0;
      tx_sel <= 1'b0;
      quiet  <= 1'b0;
    end else if (ctl_wr) begin
      rx_sel <= reg_wdata[5];
      tx_sel <= reg_wdata[4];
      quiet  <= reg_wdata[7:6] == 2'b00 && !reg_wdata[3] && |reg_wdata[5:4];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  clkout_off_a: assert property (!clock_out_oe [*2] |-> !clock_out)
    else $error("clock out active while disabled");
  oe_follow_a: assert property (reg_wr && reg_addr == 8'hc9 |=> clock_out_oe == $past(reg_wdata[1]))
    else $error("clock out enable does not follow mode write");
  baud_gate_a: assert property (!serial_mode[0] |-> !rx_baud_tick && !tx_baud_tick)
    else $error("baud tick outside modes 1 and 3");
  rx_src_a: assert property (serial_mode[0] && !rx_sel |-> rx_baud_tick == timer1_overflow)
    else $error("receive tick not from timer 1");
  tx_src_a: assert property (serial_mode[0] && !tx_sel |-> tx_baud_tick == timer1_overflow)
    else $error("transmit tick not from timer 1");
  baud_rate_a: assert property (rx_baud_tick && rx_sel |=> !rx_baud_tick || !rx_sel)
    else $error("baud ticks closer than two clocks");
  ext_irq_a: assert property (ctl_wr && reg_wdata[6] |=> timer_irq_req)
    else $error("external flag write gave no request");
  baud_quiet_a: assert property (quiet |-> !timer_irq_req)
    else $error("flag set in baud mode");
  irq_mask_a: assert property (reg_wr && reg_addr == 8'hcf && reg_wdata[1:0] == 2'b00 |=> !irq)
    else $error("interrupt high with all masked");
  cover property (rx_baud_tick && rx_sel);
  cover property (clock_out);
  cover property (irq);
endmodule // tmr2_sva

bind tmr2_timer tmr2_sva #(.SLOW_DIV(SLOW_DIV)) u_sva (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .clock_out(clock_out), .clock_out_oe(clock_out_oe), .timer1_overflow(timer1_overflow),
  .serial_mode(serial_mode), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
  .timer_irq_req(timer_irq_req), .irq(irq));

// file: bench/tmr2_pin_model.sv
// Model of the external count and trigger pins
`timescale 1ns/1ps
module tmr2_pin_model (
  // Clock
  input  wire clk_sys,
  // Requests
  input  wire cnt_fall,
  input  wire trig_fall,
  input  wire trig_hold_low,
  // Pins
  output wire count_input_pin,
  output wire trigger_pin
);
  reg [2:0] cnt_low;
  reg [2:0] trig_low;
  initial begin
    cnt_low  = 3'h0;
    trig_low = 3'h0;
  end
  // Low for four clocks so the two-stage synchroniser cannot miss it
  always @(posedge clk_sys) begin
    cnt_low  <= cnt_fall ? 3'h4 : (cnt_low != 3'h0) ? cnt_low - 3'h1 : 3'h0;
    trig_low <= trig_fall ? 3'h4 : (trig_low != 3'h0) ? trig_low - 3'h1 : 3'h0;
  end
  assign count_input_pin = cnt_low == 3'h0;
  assign trigger_pin     = !(trig_low != 3'h0 || trig_hold_low);
endmodule // tmr2_pin_model

// file: bench/tb_timer_two_capture_reload.sv
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module tb_timer_two_capture_reload;
  reg         clk_sys, sys_rst, reg_wr, reg_rd, t1_ovf, cnt_fall, trig_fall, trig_low, prev_clk;
  reg  [7:0]  reg_addr, reg_wdata, val, lo, a;
  reg  [1:0]  serial_mode;
  reg  [15:0] r;
  wire [7:0]  reg_rdata;
  wire        cnt_pin, trig_pin, clock_out, clock_out_oe, rx_tick, tx_tick, irq_req, irq;
  integer     n_mismatch, comparisons, n, m, n_rx, n_tx, n_clk, s_rx, s_tx, s_clk;
  tmr2_timer #(.SLOW_DIV(1)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_input_pin(cnt_pin), .trigger_pin(trig_pin), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .timer1_overflow(t1_ovf), .serial_mode(serial_mode), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .timer_irq_req(irq_req), .irq(irq));
  tmr2_pin_model pins (.clk_sys(clk_sys), .cnt_fall(cnt_fall), .trig_fall(trig_fall),
    .trig_hold_low(trig_low), .count_input_pin(cnt_pin), .trigger_pin(trig_pin));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    t1_ovf   <= $urandom_range(1, 0);
    n_rx     <= n_rx + rx_tick;
    n_tx     <= n_tx + tx_tick;
    n_clk    <= n_clk + (clock_out != prev_clk);
    prev_clk <= clock_out;
  end
  // ****
  // Tasks
  // ****
  task chk(input string s, input [15:0] e, input [15:0] g);
    comparisons = comparisons + 1;
    if (e !== g) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task get(input [7:0] ad);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 val = reg_rdata;
  endtask
  task rd(input [7:0] ad, input string s, input [7:0] e);
    get(ad);
    chk(s, e, val);
  endtask
  task pin(input t);
    @(posedge clk_sys);
    if (t) trig_fall <= 1'b1;
    else cnt_fall <= 1'b1;
    @(posedge clk_sys);
    trig_fall <= 1'b0;
    cnt_fall  <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {n_mismatch, comparisons, n_rx, n_tx, n_clk} = 0;
    {sys_rst, reg_wr, reg_rd, t1_ovf, cnt_fall, trig_fall, trig_low, prev_clk} = 8'h80;
    {reg_addr, reg_wdata, serial_mode} = 0;
    r = $urandom(93);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (a = 8'hc7; a != 8'hd0; a = a + 8'h01) rd(a, "reset value", 8'h00);
    wr(8'hc9, 8'hff);
    rd(8'hc9, "mode", 8'h0b);
    wr(8'hc9, 8'h00);
    // Reload: start one step below wrap, internal tick every clock
    r = $urandom_range(16'hefff, 0);
    wr(8'hca, r[7:0]);
    wr(8'hcb, r[15:8]);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hcf, 8'h01);
    wr(8'hc8, 8'h04);
    repeat (6) @(posedge clk_sys);
    wr(8'hc8, 8'h80);
    rd(8'hc8, "control", 8'h80);
    get(8'hcc);
    lo = val;
    get(8'hcd);
    chk("reload", 1, {val, lo} >= r && {val, lo} <= r + 16'd16);
    repeat (20) @(posedge clk_sys);
    rd(8'hcc, "held count", lo);
    rd(8'hce, "status", 8'h01);
    chk("irq set", 1, irq);
    wr(8'hce, 8'h01);
    #1 chk("irq cleared", 0, irq);
    // Capture of pin-counted edges
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h0f);
    n = $urandom_range(6, 1);
    repeat (n) pin(0);
    pin(1);
    rd(8'hca, "capture low", n[7:0]);
    rd(8'hcb, "capture high", 8'h00);
    rd(8'hc8, "control", 8'h4f);
    rd(8'hce, "status", 8'h02);
    wr(8'hcf, 8'h02);
    #1 chk("irq set", 1, irq);
    wr(8'hce, 8'h02);
    #1 chk("irq cleared", 0, irq);
    wr(8'hc9, 8'h08);
    m = $urandom_range(6, 1);
    repeat (m) pin(0);
    pin(1);
    rd(8'hca, "capture low", n[7:0] + m[7:0]);
    rd(8'hcc, "cleared count", 8'h00);
    wr(8'hc8, 8'h07);
    pin(1);
    rd(8'hc8, "control", 8'h07);
    rd(8'hca, "capture low", n[7:0] + m[7:0]);
    // Down count while the trigger pin stays low
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h01);
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'h00);
    wr(8'hcc, 8'h05);
    wr(8'hcd, 8'h00);
    trig_low <= 1'b1;
    wr(8'hc8, 8'h06);
    repeat (3) pin(0);
    rd(8'hcc, "down count", 8'h02);
    wr(8'hc8, 8'h00);
    wr(8'hce, 8'h02);
    rd(8'hce, "status cleared", 8'h00);
    wr(8'hc8, 8'h40);
    rd(8'hce, "soft ext status", 8'h02);
    wr(8'hc8, 8'h00);
    wr(8'hce, 8'h02);
    trig_low <= 1'b0;
    // Baud mode with reload of all ones: a tick every second clock
    wr(8'hc9, 8'h02);
    for (a = 8'hca; a != 8'hce; a = a + 8'h01) wr(a, 8'hff);
    serial_mode <= 2'b01;
    wr(8'hc8, 8'h34);
    repeat (4) @(posedge clk_sys);
    #1 {s_rx, s_tx, s_clk} = {n_rx, n_tx, n_clk};
    repeat (40) @(posedge clk_sys);
    #1 chk("rx ticks", 20, n_rx - s_rx);
    chk("tx ticks", 20, n_tx - s_tx);
    chk("clock out toggles", 20, n_clk - s_clk);
    rd(8'hc8, "control", 8'h34);
    summarize;
  end
endmodule // tb_timer_two_capture_reload
